/* File: src/tdr_pkg.sv */
`default_nettype none

package tdr_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Symbol and deserializer geometry
  localparam int SYM_W = 10;            // Bits per recovered symbol
  localparam int FIFO_DEPTH = 4;        // Raw characters in flight
  localparam logic [2:0] PCNT_RST = 3'h0;   // First bit pair of a char
  localparam logic [2:0] PCNT_LAST = 3'h4;  // Fifth and last bit pair

  ////////////////////////////////////////////////////////////////////////
  // The four control tokens sent during blanking
  localparam logic [9:0] TOK_CTL0 = 10'h354;
  localparam logic [9:0] TOK_CTL1 = 10'h0AB;
  localparam logic [9:0] TOK_CTL2 = 10'h154;
  localparam logic [9:0] TOK_CTL3 = 10'h2AB;

  // Token runs that count as proof of a clean sample point
  localparam logic [7:0] RUN_HDMI = 8'h0C;  // Short blanking run
  localparam logic [7:0] RUN_DVI = 8'h80;   // Long blanking run

  // Pixel cycles to wait for a token run, longer than one video line
  localparam logic [15:0] TIMEOUT_DEF = 16'h0898;

  ////////////////////////////////////////////////////////////////////////
  // Phase shift range of the clock synthesizer, in steps
  localparam logic signed [8:0] PHASE_MAX = 9'sh096;
  localparam logic signed [8:0] PHASE_MIN = -9'sh096;
  localparam logic signed [8:0] PHASE_HOME = 9'sh000;

  ////////////////////////////////////////////////////////////////////////
  // Aligner sequencing
  typedef enum logic [1:0] {ST_EVAL, ST_STEP, ST_ACK, ST_LOCK} tdr_state_e;

  // What the current phase sweep is looking for
  typedef enum logic [2:0] {
    GL_START,   // First look at the untouched phase
    GL_LEAVE,   // Start landed in an eye: walk out of it
    GL_EYE,     // Walking through jitter towards the next eye
    GL_JIT,     // Walking through the eye towards the next jitter
    GL_CENTRE,  // Stepping back to the eye middle
    GL_REWIND   // Range exhausted: return home and retry
  } tdr_goal_e;

  // Phase step request to the clock synthesizer
  typedef struct packed {
    logic en;   // One-cycle request pulse
    logic inc;  // 1 = later phase, 0 = earlier phase
  } tdr_step_s;

  // Recovered symbol towards deskew
  typedef struct packed {
    logic valid;
    logic [9:0] data;
  } tdr_sym_s;

  // Complete state of one lane
  typedef struct packed {
    logic [2:0] ck;                          // Pixel clock samples
    logic [9:0] shift;                       // Deserializer shifter
    logic [2:0] pcnt;                        // Bit pair counter
    logic raw_v;                             // Window holds data
    logic [19:0] win;                        // Last two raw chars
    logic [3:0] off;                         // Word boundary offset
    logic [7:0] run;                         // Consecutive tokens
    logic [15:0] timer;                      // Pixel cycles waited
    tdr_state_e state;
    tdr_goal_e goal;
    logic signed [8:0] pos;                  // Net phase steps
    logic signed [8:0] eye_start_phase;
    logic signed [8:0] jitter_start_phase;
    logic [8:0] back;                        // Steps left to centre
    tdr_step_s step;
    logic lock;
    tdr_sym_s sym;
  } tdr_lane_s;

  localparam tdr_lane_s LANE_RST = '0;

  // True when a ten-bit word is one of the control tokens
  function automatic logic tdr_is_token(input logic [9:0] w);
    return (w == TOK_CTL0) || (w == TOK_CTL1) ||
           (w == TOK_CTL2) || (w == TOK_CTL3);
  endfunction

endpackage

`default_nettype wire

/* File: src/tdr_fifo.sv */
`timescale 1ns/10ps
`default_nettype none

module tdr_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Fill side
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  input wire logic [WIDTH-1:0] wr_data_in,
  // Drain side
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output logic [WIDTH-1:0] rd_data_out
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] CNT_FULL = (AW + 1)'(DEPTH);

  // Depth must be a power of two so the pointers wrap by themselves
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("tdr_fifo: DEPTH must be a power of two, at least 2");
  end
  if (WIDTH < 1) begin : g_bad_width
    $error("tdr_fifo: WIDTH must be at least 1");
  end

  // Whole buffer state
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;  // Storage words
    logic [AW-1:0] wp;                 // Next slot to fill
    logic [AW-1:0] rp;                 // Next slot to drain
    logic [AW:0] cnt;                  // Words held
  } tdr_fifo_s;

  tdr_fifo_s r;
  tdr_fifo_s n;
  logic push;
  logic pop;

  ////////////////////////////////////////////////////////////////////////
  // Honest flags straight from the fill count
  assign wr_ready_out = (r.cnt != CNT_FULL);
  assign rd_valid_out = (r.cnt != '0);
  assign rd_data_out = r.mem[r.rp];
  assign push = wr_valid_in && wr_ready_out;
  assign pop = rd_valid_out && rd_ready_in;

  ////////////////////////////////////////////////////////////////////////
  // Next buffer state
  always_comb begin
    n = r;
    if (push) begin
      n.mem[r.wp] = wr_data_in;
      n.wp = r.wp + 1'b1;
    end
    if (pop) begin
      n.rp = r.rp + 1'b1;
    end
    // Count only moves when one side acts alone
    if (push && !pop) begin
      n.cnt = r.cnt + 1'b1;
    end else if (pop && !push) begin
      n.cnt = r.cnt - 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

endmodule

`default_nettype wire

/* File: src/tdr_lane.sv */
`timescale 1ns/10ps
`default_nettype none

module tdr_lane #(
  // Pixel cycles allowed per trial phase
  parameter logic [15:0] TIMEOUT_PIX = tdr_pkg::TIMEOUT_DEF
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Forwarded pixel clock pin
  input wire logic pix_clk_in,
  // Bit pairs from the dual-edge input register
  input wire logic rise_bit_in,
  input wire logic fall_bit_in,
  input wire logic pair_valid_in,
  output logic pair_ready_out,
  // Phase step handshake with the clock synthesizer
  output var tdr_pkg::tdr_step_s ps_req_out,
  input wire logic ps_done_in,
  // Lock state of the two other lanes
  input wire logic [1:0] peers_locked_in,
  // Results
  output logic lock_out,
  output var tdr_pkg::tdr_sym_s symbol_out,
  output logic signed [8:0] phase_pos_out
);

  ////////////////////////////////////////////////////////////////////////
  // Parameter checks

  // A timeout shorter than a long token run could never see one
  if (TIMEOUT_PIX <= 16'(tdr_pkg::RUN_DVI)) begin : g_bad_timeout
    $error("tdr_lane: TIMEOUT_PIX must exceed the long token run");
  end

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  tdr_pkg::tdr_lane_s r;         // Registered lane state
  tdr_pkg::tdr_lane_s n;         // Next lane state
  logic pix_en;                  // One cycle per pixel clock rise
  logic char_push;               // Fifth pair completes a character
  logic [9:0] char_word;         // Character being completed
  logic fifo_ready;              // Room for another character
  logic raw_valid;               // A raw character is waiting
  logic [9:0] raw_data;          // Oldest raw character
  logic [9:0] hit;               // Token seen at each offset
  logic [9:0] cur_word;          // Word at the chosen offset
  logic cur_tok;                 // That word is a token
  logic [3:0] first_hit;         // Lowest offset holding a token
  logic [7:0] run_nxt;           // Token run after this pixel
  logic decide;                  // Trial phase has a verdict
  logic eye;                     // Verdict: sample point is clean
  logic signed [9:0] span;       // Jitter start minus eye start
  logic at_limit;                // Next step would leave the range

  ////////////////////////////////////////////////////////////////////////
  // Pixel clock edge finder

  // The pixel clock has no idle level, so an edge seen just after reset
  // is harmless: the buffer is still empty and nothing is popped
  // Pixel clock only sampled; rising edge gives the pixel enable
  assign pix_en = r.ck[1] && !r.ck[2];

  ////////////////////////////////////////////////////////////////////////
  // Deserializer front end

  // Five pairs of bits per pixel make the ten-bit character
  assign char_push = pair_valid_in && (r.pcnt == tdr_pkg::PCNT_LAST);
  // The rising bit came from the true fast clock and the falling bit from
  // the inverted one, so each pair covers two bit times
  // Newest pair enters at the top, first bit ends in bit zero
  assign char_word = {fall_bit_in, rise_bit_in, r.shift[9:2]};
  // Stall the source when the last pair finds the buffer full
  assign pair_ready_out = !(r.pcnt == tdr_pkg::PCNT_LAST) || fifo_ready;

  ////////////////////////////////////////////////////////////////////////
  // Character buffer into the pixel-paced logic
  // Backpressure: the fifth pair waits rather than losing a character

  tdr_fifo #(
    .WIDTH(tdr_pkg::SYM_W),
    .DEPTH(tdr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .wr_valid_in(char_push),
    .wr_ready_out(fifo_ready),
    .wr_data_in(char_word),
    .rd_valid_out(raw_valid),
    .rd_ready_in(pix_en),
    .rd_data_out(raw_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // Token search over every offset of the two-character window
  // A token may straddle two raw characters, hence all ten offsets

  for (genvar k = 0; k < 10; k++) begin : g_hit
    assign hit[k] = tdr_pkg::tdr_is_token(r.win[k +: 10]);
  end

  // Word at the current boundary
  assign cur_word = r.win[r.off +: 10];
  assign cur_tok = hit[r.off];

  // Lowest offset that shows a token
  always_comb begin
    first_hit = 4'h0;
    for (int i = 9; i >= 0; i--) begin
      if (hit[i]) begin
        first_hit = 4'(i);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Trial phase verdict

  // Characters still buffered when a step lands were sampled at the old
  // phase; they are fewer than the short run, so they cannot fake an eye
  // Token run, held at the long run length once reached
  always_comb begin
    if (!cur_tok) begin
      run_nxt = 8'h00;
    end else if (r.run == tdr_pkg::RUN_DVI) begin
      run_nxt = r.run;
    end else begin
      run_nxt = r.run + 8'h01;
    end
  end

  // Either a short or a long run proves a clean sample point
  always_comb begin
    eye = (run_nxt == tdr_pkg::RUN_HDMI) ||
          (run_nxt == tdr_pkg::RUN_DVI);
    decide = 1'b0;
    if (r.state == tdr_pkg::ST_EVAL && pix_en && r.raw_v) begin
      // No run before the timeout means jitter
      decide = eye || (r.timer + 16'h0001 >= TIMEOUT_PIX);
    end
  end

  // Full width of the found eye
  assign span = 10'(r.pos) - 10'(r.eye_start_phase);

  // Refuse a step that would run past the synthesizer's range
  // Beyond it the real phase would stop while the net count kept going,
  // leaving the recorded eye edges meaningless
  always_comb begin
    if (r.step.inc) begin
      at_limit = (r.pos == tdr_pkg::PHASE_MAX);
    end else begin
      at_limit = (r.pos == tdr_pkg::PHASE_MIN);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Next lane state

  always_comb begin
    n = r;
    n.step.en = 1'b0;

    // Two-stage synchroniser plus history for the edge finder
    n.ck = {r.ck[1], r.ck[0], pix_clk_in};

    // Shift in each pair; inverted-edge bit now sits in the true domain
    if (pair_valid_in && pair_ready_out) begin
      n.shift = char_word;
      if (r.pcnt == tdr_pkg::PCNT_LAST) begin
        n.pcnt = tdr_pkg::PCNT_RST;
      end else begin
        n.pcnt = r.pcnt + 3'h1;
      end
    end

    // One raw character per pixel slides the window along
    if (pix_en && raw_valid) begin
      n.win = {raw_data, r.win[19:10]};
      n.raw_v = 1'b1;
    end

    // Aligner: one trial per phase, one step outstanding at a time
    unique case (r.state)
      // Watch tokens at the present phase
      tdr_pkg::ST_EVAL: begin
        if (pix_en && r.raw_v) begin
          n.run = run_nxt;
          n.timer = r.timer + 16'h0001;
          // Move the boundary to a token seen at another offset
          if (!cur_tok && (hit != 10'h000)) begin
            n.off = first_hit;
            n.run = 8'h00;
          end
        end
        if (decide) begin
          n.state = tdr_pkg::ST_STEP;
          n.step.inc = 1'b1;
          if (r.goal == tdr_pkg::GL_START) begin
            // Landing in an eye means abandoning it first
            if (eye) begin
              n.goal = tdr_pkg::GL_LEAVE;
            end else begin
              n.goal = tdr_pkg::GL_EYE;
            end
          end else if (r.goal == tdr_pkg::GL_LEAVE) begin
            // Next jitter zone reached, now hunt the next eye
            if (!eye) begin
              n.goal = tdr_pkg::GL_EYE;
            end
          end else if (r.goal == tdr_pkg::GL_EYE) begin
            // First clean phase is where the eye opens
            if (eye) begin
              n.eye_start_phase = r.pos;
              n.goal = tdr_pkg::GL_JIT;
            end
          end else if (r.goal == tdr_pkg::GL_JIT) begin
            // First noisy phase after it is where jitter begins
            if (!eye) begin
              n.jitter_start_phase = r.pos;
              n.back = span[9:1];
              n.goal = tdr_pkg::GL_CENTRE;
              n.step.inc = 1'b0;
              if (span[9:1] == 9'h000) begin
                n.state = tdr_pkg::ST_LOCK;
              end
            end
          end
        end
      end

      // Issue one step, or give up the sweep at the range end
      tdr_pkg::ST_STEP: begin
        if (at_limit) begin
          n.goal = tdr_pkg::GL_REWIND;
          n.step.inc = (r.pos < tdr_pkg::PHASE_HOME);
          if (r.pos == tdr_pkg::PHASE_HOME) begin
            n.goal = tdr_pkg::GL_START;
            n.state = tdr_pkg::ST_EVAL;
            n.run = 8'h00;
            n.timer = 16'h0000;
          end
        end else begin
          n.step.en = 1'b1;
          if (r.step.inc) begin
            n.pos = r.pos + 9'sh001;
          end else begin
            n.pos = r.pos - 9'sh001;
          end
          n.state = tdr_pkg::ST_ACK;
        end
      end

      // Hold off until the synthesizer reports the step done
      tdr_pkg::ST_ACK: begin
        if (ps_done_in) begin
          if (r.goal == tdr_pkg::GL_CENTRE) begin
            // Back off without re-measuring until the middle
            n.back = r.back - 9'h001;
            if (r.back == 9'h001) begin
              n.state = tdr_pkg::ST_LOCK;
            end else begin
              n.state = tdr_pkg::ST_STEP;
            end
          end else if (r.goal == tdr_pkg::GL_REWIND) begin
            // Walk home, then start a fresh sweep
            if (r.pos == tdr_pkg::PHASE_HOME) begin
              n.goal = tdr_pkg::GL_START;
              n.state = tdr_pkg::ST_EVAL;
              n.run = 8'h00;
              n.timer = 16'h0000;
            end else begin
              n.state = tdr_pkg::ST_STEP;
            end
          end else begin
            // Fresh trial at the new phase
            n.state = tdr_pkg::ST_EVAL;
            n.run = 8'h00;
            n.timer = 16'h0000;
          end
        end
      end

      // Centred: boundary frozen, symbols flow every pixel
      tdr_pkg::ST_LOCK: begin
        n.lock = 1'b1;
        if (pix_en && r.raw_v) begin
          n.sym.data = cur_word;
        end
        // Valid trails lock by a cycle; deskew never sees a half-set lane
        // Deskew sees data only once every lane is aligned
        n.sym.valid = r.lock && (&peers_locked_in);
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State register; this whole path exists once per lane
  // Reset loads constants only; the search restarts from the home phase

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      r <= tdr_pkg::LANE_RST;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, all from the state register

  assign ps_req_out = r.step;
  assign lock_out = r.lock;
  assign symbol_out = r.sym;
  assign phase_pos_out = r.pos;

endmodule

`default_nettype wire

/* File: bench/tdr_lane_sva.sv */
`timescale 1ns/10ps
`default_nettype none

module tdr_lane_sva (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Lane inputs
  input wire logic pix_clk_in,
  input wire logic rise_bit_in,
  input wire logic fall_bit_in,
  input wire logic pair_valid_in,
  input wire logic ps_done_in,
  input wire logic [1:0] peers_locked_in,
  // Lane outputs
  input wire logic pair_ready_out,
  input wire tdr_pkg::tdr_step_s ps_req_out,
  input wire logic lock_out,
  input wire tdr_pkg::tdr_sym_s symbol_out,
  input wire logic signed [8:0] phase_pos_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  ////////////////////////////////////////////////////////////////////////
  // Step outstanding: set by a request, cleared by the acknowledge
  logic pend_r;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pend_r <= 1'b0;
    end else if (ps_req_out.en) begin
      pend_r <= 1'b1;
    end else if (ps_done_in) begin
      pend_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  AST_STEP_PULSE: assert property (ps_req_out.en |=> !ps_req_out.en)
    else $error("step request longer than one cycle");
  AST_STEP_WAITS: assert property (ps_req_out.en |-> !pend_r)
    else $error("step request before acknowledge");
  AST_POS_STEP: assert property (ps_req_out.en |-> phase_pos_out ==
    $past(phase_pos_out) + (ps_req_out.inc ? 9'sh001 : -9'sh001))
    else $error("phase count does not follow the step");
  AST_POS_HOLD: assert property (!ps_req_out.en |-> $stable(phase_pos_out))
    else $error("phase count moved without a step");
  AST_POS_RANGE: assert property (phase_pos_out <= tdr_pkg::PHASE_MAX &&
    phase_pos_out >= tdr_pkg::PHASE_MIN)
    else $error("phase count out of range");
  AST_LOCK_STAYS: assert property (lock_out |=> lock_out)
    else $error("lock dropped");
  AST_LOCK_NO_STEP: assert property (lock_out |-> !ps_req_out.en)
    else $error("step while locked");
  AST_VALID_GATE: assert property (symbol_out.valid ==
    ($past(lock_out) && (&$past(peers_locked_in))))
    else $error("symbol valid not tied to all lanes locked");
  AST_SYM_QUIET: assert property (!lock_out |-> symbol_out == '0)
    else $error("symbol output before lock");
  COV_LOCK: cover property ($rose(lock_out));
  COV_REFUSE: cover property (pair_valid_in && !pair_ready_out);
endmodule

`default_nettype wire

/* File: bench/tdr_src_model.sv */
`timescale 1ns/10ps
`default_nettype none

module tdr_src_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Lowest phase of an open eye
  input wire logic signed [8:0] eye_lo_in,
  // Bit pair lane
  output logic rise_bit_out,
  output logic fall_bit_out,
  output logic pair_valid_out,
  input wire logic pair_ready_in,
  // Phase step handshake
  input wire tdr_pkg::tdr_step_s ps_req_in,
  output logic ps_done_out,
  // Observation
  output logic signed [8:0] phase_out,
  output logic signed [8:0] max_phase_out,
  output int refusals_out
);
  localparam int EYE_W = 6;    // Phases per eye
  localparam int EYE_PER = 12; // Eye repeat in phase steps
  logic [9:0] toks [4];
  logic [9:0] word;
  logic took, slow, b0, b1;
  int bidx, wcnt, wait_n, d;

  initial begin
    toks = '{tdr_pkg::TOK_CTL0, tdr_pkg::TOK_CTL1,
             tdr_pkg::TOK_CTL2, tdr_pkg::TOK_CTL3};
    {rise_bit_out, fall_bit_out, pair_valid_out, ps_done_out} = 4'h0;
    {took, slow, word} = '0;
    {phase_out, max_phase_out} = '0;
    bidx = 3;
    wcnt = 0;
    wait_n = 0;
    refusals_out = 0;
  end

  // Serial stream: tokens in the eye, all zero in the jitter zone
  task automatic next_bit(output logic b);
    if (bidx == 10) begin
      bidx = 0;
      wcnt++;
      d = ((int'(phase_out) - int'(eye_lo_in)) % EYE_PER + EYE_PER) % EYE_PER;
      word = (d < EYE_W) ? toks[wcnt % 4] : 10'h000;
    end
    b = word[bidx];
    bidx++;
  endtask

  // Pair driver holds each pair until it is taken
  always @(negedge clk_in) begin
    if (!reset_n_in) begin
      pair_valid_out <= 1'b0;
    end else if (!pair_valid_out || took) begin
      next_bit(b0);
      next_bit(b1);
      rise_bit_out <= b0;
      fall_bit_out <= b1;
      pair_valid_out <= 1'b1;
    end
  end

  always @(posedge clk_in) begin
    took <= pair_valid_out && pair_ready_in;
    if (pair_valid_out && !pair_ready_in) begin
      refusals_out <= refusals_out + 1;
    end
  end

  // Synthesizer: moves its phase, acknowledges fast or slow in turn
  always @(negedge clk_in) begin
    ps_done_out <= 1'b0;
    if (!reset_n_in) begin
      {phase_out, max_phase_out, wait_n} <= '0;
    end else if (ps_req_in.en) begin
      phase_out <= phase_out + (ps_req_in.inc ? 9'sh001 : -9'sh001);
      wait_n <= slow ? 6 : 1;
      slow <= !slow;
    end else if (wait_n > 0) begin
      wait_n <= wait_n - 1;
      ps_done_out <= (wait_n == 1);
    end
    if (phase_out > max_phase_out) begin
      max_phase_out <= phase_out;
    end
  end
endmodule

`default_nettype wire

/* File: bench/tb_tdr_lane.sv */
`timescale 1ns/10ps
`default_nettype none

module tb_tdr_lane;
  // Short trial so a sweep stays brief
  localparam logic [15:0] TMO = 16'h008C;
  logic clk_in, reset_n_in, pix_clk_in;
  logic rise_bit, fall_bit, pair_valid, pair_ready, ps_done, lock;
  logic [1:0] peers;
  logic signed [8:0] phase, m_phase, m_max, eye_lo;
  tdr_pkg::tdr_step_s ps_req;
  tdr_pkg::tdr_sym_s sym;
  int refusals, num_errors, total_checks;

  tdr_lane #(.TIMEOUT_PIX(TMO)) tdr_lane_inst (.clk_in(clk_in),
    .reset_n_in(reset_n_in), .pix_clk_in(pix_clk_in),
    .rise_bit_in(rise_bit), .fall_bit_in(fall_bit),
    .pair_valid_in(pair_valid), .pair_ready_out(pair_ready),
    .ps_req_out(ps_req), .ps_done_in(ps_done), .peers_locked_in(peers),
    .lock_out(lock), .symbol_out(sym), .phase_pos_out(phase));

  tdr_src_model tdr_src_model_inst (.clk_in(clk_in),
    .reset_n_in(reset_n_in), .eye_lo_in(eye_lo), .rise_bit_out(rise_bit),
    .fall_bit_out(fall_bit), .pair_valid_out(pair_valid),
    .pair_ready_in(pair_ready), .ps_req_in(ps_req), .ps_done_out(ps_done),
    .phase_out(m_phase), .max_phase_out(m_max), .refusals_out(refusals));

  // System clock and a free-running pixel clock of unrelated phase
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = !clk_in;
  end
  initial begin
    pix_clk_in = 1'b0;
    #3;
    forever #62.5 pix_clk_in = !pix_clk_in;
  end

  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
      num_errors++;
    end
  endtask

  function automatic logic is_tok(logic [9:0] w);
    return w === tdr_pkg::TOK_CTL0 || w === tdr_pkg::TOK_CTL1 ||
           w === tdr_pkg::TOK_CTL2 || w === tdr_pkg::TOK_CTL3;
  endfunction

  // Reset for five cycles, outputs must sit at their idle values
  task automatic do_reset();
    @(negedge clk_in);
    reset_n_in = 1'b0;
    repeat (5) @(negedge clk_in);
    check("ready in reset", 16'(pair_ready), 16'h0001);
    check("lock in reset", 16'(lock), 16'h0000);
    check("phase in reset", 16'(phase), 16'h0000);
    check("step in reset", 16'(ps_req), 16'h0000);
    reset_n_in = 1'b1;
  endtask

  // Sweep to lock, then judge the centre and the symbol stream
  task automatic sweep(logic signed [8:0] lo, logic signed [8:0] e);
    logic signed [8:0] j, mid;
    int n;
    j = e + 9'sh006;
    mid = j - (j - e) / 2;
    eye_lo = lo;
    peers = 2'h0;
    do_reset();
    for (n = 0; n < 25000 && lock !== 1'b1; n++) @(negedge clk_in);
    check("lock", 16'(lock), 16'h0001);
    check("centre phase", 16'(phase), 16'(mid));
    check("synth phase", 16'(m_phase), 16'(mid));
    check("jitter start seen", 16'(m_max), 16'(j));
    // Let characters sampled at the old phases drain out of the pipe
    repeat (150) @(negedge clk_in);
    check("valid without peers", 16'(sym.valid), 16'h0000);
    peers = 2'h3;
    repeat (3) @(negedge clk_in);
    check("valid with peers", 16'(sym.valid), 16'h0001);
    for (n = 0; n < 6; n++) begin
      repeat (13) @(negedge clk_in);
      check("aligned token", 16'(is_tok(sym.data)), 16'h0001);
    end
    check("lock held", 16'(lock), 16'h0001);
  endtask

  // Start in the jitter zone: eye spans phases 4 to 9
  task automatic scenario_jitter_start();
    sweep(9'sh004, 9'sh004);
    check("fifo refused", 16'(refusals > 0), 16'h0001);
  endtask

  // Start inside an eye: leave it, centre on the eye at 9 to 14
  task automatic scenario_eye_start();
    sweep(9'sh009, 9'sh009);
    check("eye dropped", 16'(phase > 9'sh008), 16'h0001);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog sized well beyond both sweeps
  initial begin
    #600000;
    num_errors++;
    $display("unexpected timeout: expected end of tests");
    summarize();
  end

  initial begin
    reset_n_in = 1'b0;
    peers = 2'h0;
    eye_lo = 9'sh004;
    num_errors = 0;
    total_checks = 0;
    scenario_jitter_start();
    scenario_eye_start();
    summarize();
  end
endmodule

bind tdr_lane tdr_lane_sva tdr_lane_sva_inst (.clk_in(clk_in),
  .reset_n_in(reset_n_in), .pix_clk_in(pix_clk_in),
  .rise_bit_in(rise_bit_in), .fall_bit_in(fall_bit_in),
  .pair_valid_in(pair_valid_in), .ps_done_in(ps_done_in),
  .peers_locked_in(peers_locked_in), .pair_ready_out(pair_ready_out),
  .ps_req_out(ps_req_out), .lock_out(lock_out), .symbol_out(symbol_out),
  .phase_pos_out(phase_pos_out));

`default_nettype wire
